// ---- include/counter_pkg.sv ----
// constants shared by the scan counter block: register map, fields, reset values
// Summary of operation
// - down counter lowers present count by one on a count-pulse rising edge.
// - down counter holds its count when count pulse is steady or falling.
// - down counter completion flag sets at zero and holds until counter reset.
// - rising edge of down counter reset loads the preset into present count.
// - while down reset is on, pulses are ignored; counting resumes after release.
// - down counter count survives interlocks and power loss; only its reset loads it. Here presetn also clears the count to zero.
// - counts and presets are four-digit BCD, at most 9999; cascade for more.
// - non-BCD preset sets fault flag but execution continues, count may be wrong.
// - fault flag sets for missing, non-BCD or out-of-area indirect data word.
// - ring counter adds one on an increment-input rising edge.
// - ring counter subtracts one on a decrement-input rising edge.
// - ring counter holds count when both inputs rose or when neither rose.
// - decrement from zero wraps to preset; completion flag on until next decrement.
// - increment past preset wraps to zero; completion flag on until next increment.
// - rising edge of ring counter reset clears the present count to zero.
// - while ring reset is on, no counting; counting resumes after release.
// - ring counter keeps its count through interlocks and power loss. Here presetn clears the count to zero.
package counter_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int BCD_W = 16;
    localparam int DIGITS = 4;
    localparam logic [3:0] BCD_NINE = 4'h9;
    localparam logic [3:0] BCD_ZERO = 4'h0;
    localparam logic [BCD_W-1:0] COUNT_RST = 16'h0000;
    localparam logic [BCD_W-1:0] PRESET_RST = 16'h0000;

    localparam logic [ADDR_W-1:0] OFF_COND = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_DOWN_PRESET = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_RING_PRESET = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_CFG = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_DOWN_COUNT = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_RING_COUNT = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_FLAGS = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h1c;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h20;
    localparam logic [ADDR_W-1:0] OFF_DM_BASE = 8'h40;

    localparam int COND_W = 5;
    localparam int COND_PULSE = 0;
    localparam int COND_DOWN_RST = 1;
    localparam int COND_INC = 2;
    localparam int COND_DEC = 3;
    localparam int COND_RING_RST = 4;

    localparam int CFG_W = 2;
    localparam int CFG_DOWN_IND = 0;
    localparam int CFG_RING_IND = 1;

    localparam int EVT_W = 3;
    localparam int EVT_DOWN_DONE = 0;
    localparam int EVT_RING_DONE = 1;
    localparam int EVT_FAULT = 2;

    localparam int DM_DEPTH = 8;
    localparam int DM_AW = 3;
    localparam int WORD_LSB = 2;
endpackage

// ---- src/scan_counter.sv ----
// down counter and up/down ring counter evaluated once per scan, apb register access
//
// Design decisions made here: the placing of the registers and the APB register port.
`timescale 1ns/1ns
module scan_counter (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [counter_pkg::ADDR_W-1:0] paddr,
    input wire logic [counter_pkg::DATA_W-1:0] pwdata,
    output logic [counter_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq
);
    localparam int BW = counter_pkg::BCD_W;

    function automatic logic bcd_ok(input logic [BW-1:0] v);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < counter_pkg::DIGITS; i++) begin
            if (v[i*4 +: 4] > counter_pkg::BCD_NINE) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction

    // digit-wise bcd step; a non-bcd digit is stepped blindly, as the count may then be wrong
    function automatic logic [BW-1:0] bcd_step(input logic [BW-1:0] v, input logic up);
        logic [BW-1:0] r;
        logic carry;
        logic [3:0] d;
        r = v;
        carry = 1'b1;
        for (int i = 0; i < counter_pkg::DIGITS; i++) begin
            d = v[i*4 +: 4];
            if (carry) begin
                if (up) begin
                    if (d >= counter_pkg::BCD_NINE) begin
                        d = counter_pkg::BCD_ZERO;
                    end else begin
                        d = d + 4'h1;
                        carry = 1'b0;
                    end
                end else begin
                    if (d == counter_pkg::BCD_ZERO) begin
                        d = counter_pkg::BCD_NINE;
                    end else begin
                        d = d - 4'h1;
                        carry = 1'b0;
                    end
                end
            end
            r[i*4 +: 4] = d;
        end
        return r;
    endfunction

    // indirect preset: index must be a bcd value inside the data memory area
    function automatic logic idx_ok(input logic [BW-1:0] v);
        return bcd_ok(v) && (v < BW'(counter_pkg::DM_DEPTH));
    endfunction

    logic [counter_pkg::COND_W-1:0] cond_q;
    logic [counter_pkg::COND_W-1:0] prev_q;
    logic [BW-1:0] down_preset_q;
    logic [BW-1:0] ring_preset_q;
    logic [counter_pkg::CFG_W-1:0] cfg_q;
    logic [BW-1:0] down_count_q;
    logic [BW-1:0] down_count_d;
    logic [BW-1:0] ring_count_q;
    logic [BW-1:0] ring_count_d;
    logic down_done_q;
    logic down_done_d;
    logic ring_done_q;
    logic ring_done_d;
    logic fault_q;
    logic [counter_pkg::EVT_W-1:0] sts_q;
    logic [counter_pkg::EVT_W-1:0] mask_q;
    logic [BW-1:0] dm_q [counter_pkg::DM_DEPTH];
    logic [counter_pkg::DATA_W-1:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic irq_q;

    // apb decode; the answer takes one wait state so read data can come from a flop
    wire access = psel & penable;
    wire first = access & ~pready_q;
    wire commit = access & pready_q;
    wire wr = commit & pwrite;
    wire [counter_pkg::ADDR_W-1:0] dm_lo = counter_pkg::OFF_DM_BASE;
    wire [counter_pkg::ADDR_W-1:0] dm_span =
        counter_pkg::ADDR_W'(counter_pkg::DM_DEPTH << counter_pkg::WORD_LSB);
    wire sel_dm = (paddr >= dm_lo) && (paddr < dm_lo + dm_span);
    wire [counter_pkg::DM_AW-1:0] dm_wa = paddr[counter_pkg::WORD_LSB +: counter_pkg::DM_AW];
    wire sel_cond = paddr == counter_pkg::OFF_COND;
    wire sel_dpre = paddr == counter_pkg::OFF_DOWN_PRESET;
    wire sel_rpre = paddr == counter_pkg::OFF_RING_PRESET;
    wire sel_cfg = paddr == counter_pkg::OFF_CFG;
    wire sel_dcnt = paddr == counter_pkg::OFF_DOWN_COUNT;
    wire sel_rcnt = paddr == counter_pkg::OFF_RING_COUNT;
    wire sel_flags = paddr == counter_pkg::OFF_FLAGS;
    wire sel_sts = paddr == counter_pkg::OFF_IRQ_STATUS;
    wire sel_mask = paddr == counter_pkg::OFF_IRQ_MASK;
    wire mapped = sel_cond | sel_dpre | sel_rpre | sel_cfg | sel_dcnt | sel_rcnt
                | sel_flags | sel_sts | sel_mask | sel_dm;

    // each write of the condition word is one scan evaluation
    wire eval = wr & sel_cond;
    wire [counter_pkg::COND_W-1:0] c = pwdata[counter_pkg::COND_W-1:0];
    wire [counter_pkg::COND_W-1:0] rise = c & ~prev_q;

    // effective presets, direct or through the data memory area
    wire down_ind = cfg_q[counter_pkg::CFG_DOWN_IND];
    wire ring_ind = cfg_q[counter_pkg::CFG_RING_IND];
    wire [counter_pkg::DM_AW-1:0] down_ix = down_preset_q[counter_pkg::DM_AW-1:0];
    wire [counter_pkg::DM_AW-1:0] ring_ix = ring_preset_q[counter_pkg::DM_AW-1:0];
    wire [BW-1:0] down_sv = down_ind ? dm_q[down_ix] : down_preset_q;
    wire [BW-1:0] ring_sv = ring_ind ? dm_q[ring_ix] : ring_preset_q;
    wire down_ind_bad = down_ind & ~idx_ok(down_preset_q);
    wire ring_ind_bad = ring_ind & ~idx_ok(ring_preset_q);
    // the bad-index check already covers a missing word, so the content is checked too
    wire fault_now = down_ind_bad | ring_ind_bad | ~bcd_ok(down_sv) | ~bcd_ok(ring_sv);

    // down counter next state
    always_comb begin
        down_count_d = down_count_q;
        down_done_d = down_done_q;
        if (rise[counter_pkg::COND_DOWN_RST]) begin
            down_count_d = down_sv;
            down_done_d = down_sv == counter_pkg::COUNT_RST;
        end else if (c[counter_pkg::COND_DOWN_RST]) begin
            down_count_d = down_count_q;
        end else if (rise[counter_pkg::COND_PULSE]
                     && down_count_q != counter_pkg::COUNT_RST) begin
            down_count_d = bcd_step(down_count_q, 1'b0);
            down_done_d = down_count_d == counter_pkg::COUNT_RST;
        end
        // otherwise steady or falling pulse: count and flag hold
    end

    // ring counter next state
    wire inc_r = rise[counter_pkg::COND_INC];
    wire dec_r = rise[counter_pkg::COND_DEC];
    always_comb begin
        ring_count_d = ring_count_q;
        ring_done_d = ring_done_q;
        if (rise[counter_pkg::COND_RING_RST]) begin
            ring_count_d = counter_pkg::COUNT_RST;
            ring_done_d = 1'b0;
        end else if (c[counter_pkg::COND_RING_RST]) begin
            ring_count_d = ring_count_q;
        end else if (inc_r && !dec_r) begin
            if (ring_count_q >= ring_sv) begin
                ring_count_d = counter_pkg::COUNT_RST;
                ring_done_d = 1'b1;
            end else begin
                ring_count_d = bcd_step(ring_count_q, 1'b1);
                ring_done_d = 1'b0;
            end
        end else if (dec_r && !inc_r) begin
            if (ring_count_q == counter_pkg::COUNT_RST) begin
                ring_count_d = ring_sv;
                ring_done_d = 1'b1;
            end else begin
                ring_count_d = bcd_step(ring_count_q, 1'b0);
                ring_done_d = 1'b0;
            end
        end
        // both rose or neither rose: hold
    end

    // counts change only on an evaluation or on presetn; a ring reset evaluation also clears the ring count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_q <= '0;
            cond_q <= '0;
            down_count_q <= counter_pkg::COUNT_RST;
            ring_count_q <= counter_pkg::COUNT_RST;
            down_done_q <= 1'b0;
            ring_done_q <= 1'b0;
            fault_q <= 1'b0;
        end else if (eval) begin
            prev_q <= c;
            cond_q <= c;
            down_count_q <= down_count_d;
            ring_count_q <= ring_count_d;
            down_done_q <= down_done_d;
            ring_done_q <= ring_done_d;
            fault_q <= fault_now;
        end
    end

    // software-written configuration and presets
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            down_preset_q <= counter_pkg::PRESET_RST;
            ring_preset_q <= counter_pkg::PRESET_RST;
            cfg_q <= '0;
            mask_q <= '0;
        end else if (wr) begin
            if (sel_dpre) begin
                down_preset_q <= pwdata[BW-1:0];
            end
            if (sel_rpre) begin
                ring_preset_q <= pwdata[BW-1:0];
            end
            if (sel_cfg) begin
                cfg_q <= pwdata[counter_pkg::CFG_W-1:0];
            end
            if (sel_mask) begin
                mask_q <= pwdata[counter_pkg::EVT_W-1:0];
            end
        end
    end

    // data memory words have no reset; retained content, unlike the counts, which presetn clears
    always_ff @(posedge pclk) begin
        if (wr && sel_dm) begin
            dm_q[dm_wa] <= pwdata[BW-1:0];
        end
    end

    // sticky events, write one to clear; a new event beats a clear in the same cycle
    wire [counter_pkg::EVT_W-1:0] evt_set = eval ? {
        fault_now,
        ring_done_d & ~ring_done_q,
        down_done_d & ~down_done_q} : '0;
    wire [counter_pkg::EVT_W-1:0] evt_clr = (wr & sel_sts) ? pwdata[counter_pkg::EVT_W-1:0] : '0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sts_q <= '0;
            irq_q <= 1'b0;
        end else begin
            sts_q <= (sts_q & ~evt_clr) | evt_set;
            irq_q <= |(((sts_q & ~evt_clr) | evt_set) & mask_q);
        end
    end

    // read mux
    wire [counter_pkg::EVT_W-1:0] flags = {fault_q, ring_done_q, down_done_q};
    logic [counter_pkg::DATA_W-1:0] rd_mux;
    always_comb begin
        rd_mux = '0;
        if (sel_cond) begin
            rd_mux = counter_pkg::DATA_W'(cond_q);
        end else if (sel_dpre) begin
            rd_mux = counter_pkg::DATA_W'(down_preset_q);
        end else if (sel_rpre) begin
            rd_mux = counter_pkg::DATA_W'(ring_preset_q);
        end else if (sel_cfg) begin
            rd_mux = counter_pkg::DATA_W'(cfg_q);
        end else if (sel_dcnt) begin
            rd_mux = counter_pkg::DATA_W'(down_count_q);
        end else if (sel_rcnt) begin
            rd_mux = counter_pkg::DATA_W'(ring_count_q);
        end else if (sel_flags) begin
            rd_mux = counter_pkg::DATA_W'(flags);
        end else if (sel_sts) begin
            rd_mux = counter_pkg::DATA_W'(sts_q);
        end else if (sel_mask) begin
            rd_mux = counter_pkg::DATA_W'(mask_q);
        end else if (sel_dm) begin
            rd_mux = counter_pkg::DATA_W'(dm_q[dm_wa]);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= '0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= first;
            // error stands only beside ready, so it must drop together with it
            pslverr_q <= first & ~mapped;
            if (first) begin
                prdata_q <= pwrite ? '0 : rd_mux;
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign irq = irq_q;
endmodule

// ---- bench/scan_counter_properties.sv ----
// concurrent checks on the apb port and interrupt output of the scan counter
`timescale 1ns/1ns
module scan_counter_properties (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [counter_pkg::ADDR_W-1:0] paddr,
    input wire logic [counter_pkg::DATA_W-1:0] pwdata,
    input wire logic [counter_pkg::DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic count_rd = pready && !pwrite && (paddr == counter_pkg::OFF_DOWN_COUNT
        || paddr == counter_pkg::OFF_RING_COUNT);
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence wait_s;
        psel && penable && !pready;
    endsequence
    a_one_wait: assert property (setup_s ##1 (psel && penable) |-> wait_s ##1 pready)
        else $error("ready not after exactly one wait state");
    a_ready_single: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    a_ready_access: assert property (pready |-> psel && penable)
        else $error("ready outside an access phase");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("error response without ready");
    a_unmapped_err: assert property (pready && paddr == 8'h24 |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_mapped_ok: assert property (pready && paddr <= counter_pkg::OFF_IRQ_MASK
        && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("mapped register refused");
    a_count_bcd: assert property (count_rd |-> prdata[31:16] == 16'h0
        && prdata[15:12] <= 4'h9 && prdata[11:8] <= 4'h9
        && prdata[7:4] <= 4'h9 && prdata[3:0] <= 4'h9)
        else $error("count read is not four bcd digits");
    a_write_quiet: assert property (pready && pwrite |-> prdata == 32'h0)
        else $error("read data driven on a write");
    a_mask_quiet: assert property (pready && pwrite && paddr == counter_pkg::OFF_IRQ_MASK
        && pwdata[2:0] == 3'h0 |-> ##2 !irq)
        else $error("interrupt stays high with all sources masked");
endmodule

// ---- bench/apb_master.sv ----
// bus-side model of the scan program: apb master issuing one transfer at a time
`timescale 1ns/1ns
module apb_master (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [counter_pkg::ADDR_W-1:0] paddr,
    output logic [counter_pkg::DATA_W-1:0] pwdata,
    input wire logic [counter_pkg::DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // a single program drives a single block, so each counter number has one user
    initial begin
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h0;
        pwdata = 32'h0;
    end
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e, output bit to);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 50);
        to = (pready !== 1'h1);
        q = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        // released lines toggle so a stale value never looks valid
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule

// ---- bench/scan_counter_test.sv ----
// self-checking bench: register defaults, both counters, fault flag and interrupt
`timescale 1ns/1ns
module scan_counter_test;
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    wire logic psel, penable, pwrite, pready, pslverr, irq;
    wire logic [7:0] paddr;
    wire logic [31:0] pwdata, prdata;
    int err_total = 0;
    int num_checks = 0;
    logic [31:0] q;
    logic e;
    bit to;
    logic [31:0] steps[$];
    always #50 pclk = ~pclk;
    apb_master bus (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    scan_counter dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %0t got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic go(input logic w, input logic [7:0] a, input logic [31:0] d);
        bus.xfer(w, a, d, q, e, to);
        if (to) begin
            err_total++;
            complete_run();
        end
    endtask
    // step word: cond in bits 31:24, done flag in bit 16, expected count in 15:0
    task automatic run_steps(input logic [7:0] cnt_a, input int flag_i);
        foreach (steps[i]) begin
            go(1'h1, counter_pkg::OFF_COND, {24'h0, steps[i][31:24]});
            go(1'h0, cnt_a, 32'h0);
            chk(q, {16'h0, steps[i][15:0]});
            go(1'h0, counter_pkg::OFF_FLAGS, 32'h0);
            chk({31'h0, q[flag_i]}, {31'h0, steps[i][16]});
            chk({31'h0, q[counter_pkg::EVT_FAULT]}, 32'h0);
        end
    endtask
    task automatic reg_defaults();
        logic [7:0] a[5] = '{8'h04, 8'h08, 8'h0c, 8'h1c, 8'h20};
        foreach (a[i]) begin
            go(1'h0, a[i], 32'h0);
            chk(q, 32'h0);
        end
        go(1'h0, 8'h24, 32'h0);
        chk({q[30:0], e}, 32'h1);
        // only evaluations or presetn may change a count, never a write to it
        go(1'h1, counter_pkg::OFF_DOWN_COUNT, 32'h5);
        go(1'h0, counter_pkg::OFF_DOWN_COUNT, 32'h0);
        chk(q, 32'h0);
    endtask
    task automatic down_count();
        go(1'h1, counter_pkg::OFF_DOWN_PRESET, 32'h10);
        steps = '{32'h02000010, 32'h00000010, 32'h01000009, 32'h01000009, 32'h00000009,
            32'h03000010, 32'h02000010, 32'h03000010, 32'h02000010, 32'h00000010,
            32'h01000009};
        run_steps(counter_pkg::OFF_DOWN_COUNT, counter_pkg::EVT_DOWN_DONE);
        go(1'h1, counter_pkg::OFF_DOWN_PRESET, 32'h1);
        steps = '{32'h02000001, 32'h00000001, 32'h01010000, 32'h00010000, 32'h01010000,
            32'h02000001};
        run_steps(counter_pkg::OFF_DOWN_COUNT, counter_pkg::EVT_DOWN_DONE);
    endtask
    task automatic ring_count();
        go(1'h1, counter_pkg::OFF_RING_PRESET, 32'h2);
        steps = '{32'h10000000, 32'h00000000, 32'h08010002, 32'h00010002, 32'h04010000,
            32'h00010000, 32'h04000001, 32'h00000001, 32'h0c000001, 32'h00000001,
            32'h08000000, 32'h00000000, 32'h14000000, 32'h10000000, 32'h14000000,
            32'h00000000, 32'h04000001};
        run_steps(counter_pkg::OFF_RING_COUNT, counter_pkg::EVT_RING_DONE);
    endtask
    task automatic fault_irq();
        go(1'h0, counter_pkg::OFF_IRQ_STATUS, 32'h0);
        chk(q, 32'h3);
        go(1'h1, counter_pkg::OFF_IRQ_STATUS, 32'h7);
        go(1'h1, counter_pkg::OFF_IRQ_MASK, 32'h7);
        go(1'h1, counter_pkg::OFF_DOWN_PRESET, 32'ha0);
        go(1'h1, counter_pkg::OFF_COND, 32'h0);
        go(1'h0, counter_pkg::OFF_FLAGS, 32'h0);
        chk({31'h0, q[2]}, 32'h1);
        chk({31'h0, irq}, 32'h1);
        go(1'h1, counter_pkg::OFF_IRQ_MASK, 32'h0);
        @(posedge pclk);
        @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        // indirect preset: index 2 is valid, index 9 is past the data memory
        go(1'h1, counter_pkg::OFF_CFG, 32'h1);
        go(1'h1, counter_pkg::OFF_DM_BASE + 8'h08, 32'h4);
        go(1'h1, counter_pkg::OFF_DOWN_PRESET, 32'h2);
        go(1'h1, counter_pkg::OFF_COND, 32'h2);
        go(1'h0, counter_pkg::OFF_DOWN_COUNT, 32'h0);
        chk(q, 32'h4);
        go(1'h1, counter_pkg::OFF_DOWN_PRESET, 32'h9);
        go(1'h1, counter_pkg::OFF_COND, 32'h0);
        go(1'h0, counter_pkg::OFF_FLAGS, 32'h0);
        chk({31'h0, q[2]}, 32'h1);
        go(1'h0, counter_pkg::OFF_IRQ_STATUS, 32'h0);
        chk(q, 32'h4);
        go(1'h1, counter_pkg::OFF_IRQ_STATUS, 32'h4);
        go(1'h0, counter_pkg::OFF_IRQ_STATUS, 32'h0);
        chk(q, 32'h0);
        go(1'h1, 8'h24, 32'h1);
        chk({31'h0, e}, 32'h1);
        go(1'h0, counter_pkg::OFF_DM_BASE + 8'h08, 32'h0);
        chk(q, 32'h4);
        // ring preset taken indirectly: a decrement from zero wraps to the stored word
        go(1'h1, counter_pkg::OFF_CFG, 32'h2);
        go(1'h1, counter_pkg::OFF_RING_PRESET, 32'h2);
        go(1'h1, counter_pkg::OFF_COND, 32'h10);
        go(1'h1, counter_pkg::OFF_COND, 32'h8);
        go(1'h0, counter_pkg::OFF_RING_COUNT, 32'h0);
        chk(q, 32'h4);
        go(1'h0, counter_pkg::OFF_FLAGS, 32'h0);
        chk(q, 32'h2);
    endtask
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'h1;
        reg_defaults();
        down_count();
        ring_count();
        fault_irq();
        complete_run();
    end
endmodule
bind scan_counter scan_counter_properties props (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
